// File: logic/teu_pkg.sv
// package of constants, types and register map for the trap entry unit
package teu_pkg;
   // ****************************************
   // widths and table layout
   // ****************************************
   localparam int unsigned TEU_ADDR_W = 32;
   localparam int unsigned TEU_TL_W = 3;
   localparam int unsigned TEU_TT_W = 9;
   localparam int unsigned TEU_CWP_W = 3;
   localparam int unsigned TEU_SLOT_SHIFT = 5;
   localparam int unsigned TEU_SLOT_INSNS = 8;
   localparam int unsigned TEU_LONG_INSNS = 32;
   localparam int unsigned TEU_LEVEL_SHIFT = 14;
   localparam logic [TEU_TT_W-1:0] TEU_SW_TT_BASE = 9'h100;
   localparam logic [TEU_TT_W-1:0] TEU_SPILL_LO = 9'h080;
   localparam logic [TEU_TT_W-1:0] TEU_FILL_HI = 9'h0FF;
   localparam logic [TEU_TT_W-1:0] TEU_FILL_LO = 9'h0C0;
   localparam logic [TEU_TT_W-1:0] TEU_INTR_TT = 9'h041;
   localparam logic [TEU_TT_W-1:0] TEU_ASYNC_TT = 9'h040;

   // ****************************************
   // processor state bits set on entry
   // ****************************************
   localparam int unsigned TEU_PS_PRIV = 2;
   localparam int unsigned TEU_PS_IE = 1;
   localparam int unsigned TEU_PS_AM = 3;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] TEU_OFF_TBASE = 8'h00;
   localparam logic [7:0] TEU_OFF_STATUS = 8'h04;
   localparam logic [7:0] TEU_OFF_MASK = 8'h08;
   localparam logic [7:0] TEU_OFF_LEVEL = 8'h0C;
   localparam logic [7:0] TEU_OFF_PROCESSOR_STATE = 8'h10;
   localparam logic [7:0] TEU_OFF_LAST = 8'h14;
   localparam logic [7:0] TEU_OFF_SPC = 8'h18;
   localparam logic [7:0] TEU_OFF_SNPC = 8'h1C;
   localparam logic [7:0] TEU_OFF_SSTATE = 8'h20;
   localparam logic [7:0] TEU_OFF_SELTL = 8'h24;
   localparam logic [31:0] TEU_TBASE_RST = 32'h0000_0000;
   localparam logic [11:0] TEU_PROCESSOR_STATE_RST = 12'h004;
   localparam int unsigned TEU_MAX_GL = 3;
   localparam int unsigned TEU_EV_W = 3;
   localparam int unsigned TEU_EV_TRAP = 0;
   localparam int unsigned TEU_EV_RET = 1;
   localparam int unsigned TEU_EV_OVF = 2;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [7:0] condition_codes;
      logic [7:0] address_space_id;
      logic [11:0] processor_state;
      logic [TEU_CWP_W-1:0] current_window_pointer;
   } teu_state_t;

   typedef struct packed {
      logic [TEU_ADDR_W-1:0] pc;
      logic [TEU_ADDR_W-1:0] next_program_counter;
      teu_state_t st;
   } teu_frame_t;

   typedef enum logic [1:0] {
      TEU_SRC_NONE,
      TEU_SRC_EXC,
      TEU_SRC_INTR,
      TEU_SRC_TCC
   } teu_src_t;
endpackage

// File: logic/teu_prio.sv
// priority picker over pending trap requests
`timescale 1ns/10ps
module teu_prio
   import teu_pkg::*;
(
   input wire logic exc_valid_i,
   input wire logic [teu_pkg::TEU_TT_W-1:0] exc_tt_i,
   input wire logic async_valid_i,
   input wire logic intr_valid_i,
   input wire logic tcc_valid_i,
   input wire logic [6:0] tcc_num_i,
   output logic take_o,
   output teu_pkg::teu_src_t src_o,
   output logic [teu_pkg::TEU_TT_W-1:0] tt_o
);
   // async errors win, then instruction faults, then interrupts, then traps from the instruction
   always_comb
   begin
      take_o = 1'b1;
      src_o = TEU_SRC_EXC;
      tt_o = exc_tt_i;
      if (async_valid_i)
      begin
         tt_o = TEU_ASYNC_TT;
      end
      else if (exc_valid_i)
      begin
         tt_o = exc_tt_i;
      end
      else if (intr_valid_i)
      begin
         src_o = TEU_SRC_INTR;
         tt_o = TEU_INTR_TT;
      end
      else if (tcc_valid_i)
      begin
         src_o = TEU_SRC_TCC;
         tt_o = TEU_SW_TT_BASE | {2'b00, tcc_num_i};
      end
      else
      begin
         take_o = 1'b0;
         src_o = TEU_SRC_NONE;
      end
   end
endmodule // teu_prio

// File: logic/teu_stack.sv
// trap stack: one saved frame per trap level
`timescale 1ns/10ps
module teu_stack
   import teu_pkg::*;
#(
   parameter int unsigned LEVELS = 6
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [teu_pkg::TEU_TL_W-1:0] wr_tl_i,
   input wire teu_pkg::teu_frame_t wr_frame_i,
   input wire logic [teu_pkg::TEU_TL_W-1:0] rd_tl_i,
   output teu_pkg::teu_frame_t rd_frame_o
);
   teu_frame_t mem_reg [LEVELS];

   // entries 1..LEVELS map to array slots 0..LEVELS-1
   for (genvar g = 0; g < LEVELS; g++)
   begin : g_ent
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            mem_reg[g] <= '0;
         else if (wr_i && wr_tl_i == TEU_TL_W'(g + 1))
            mem_reg[g] <= wr_frame_i;
      end
   end

   always_comb
   begin
      rd_frame_o = '0;
      for (int i = 0; i < LEVELS; i++)
         if (rd_tl_i == TEU_TL_W'(i + 1))
            rd_frame_o = mem_reg[i];
   end
endmodule // teu_stack

// File: logic/teu_top.sv
// trap entry unit: request arbitration, trap stack save, vector, AHB-Lite registers
`timescale 1ns/10ps
// Notes on behaviour
// - table slot holds 8 insns, some 32
// - vector is table base plus type, level displacement
// - software traps use separate upper table region
// - trap saves pc and next pc
// - trap packs codes, asi, state, window pointer
// - one stack entry per supported trap level
// - trap sets state bits, increments global level up to 3
// - window pointer changes only on spill/fill
// - four trap request sources accepted
// - check before each insn, take highest priority
// - return takes target from saved pc/npc
module teu_top
   import teu_pkg::*;
#(
   parameter int unsigned MAX_TL = 6
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // pipeline side
   input wire logic issue_i,
   input wire logic [teu_pkg::TEU_ADDR_W-1:0] pc_i,
   input wire logic [teu_pkg::TEU_ADDR_W-1:0] next_pc_i,
   input wire logic [7:0] condition_codes_i,
   input wire logic [7:0] address_space_id_i,
   input wire logic [teu_pkg::TEU_CWP_W-1:0] current_window_pointer_i,
   input wire logic exc_valid_i,
   input wire logic [teu_pkg::TEU_TT_W-1:0] exc_tt_i,
   input wire logic async_valid_i,
   input wire logic intr_valid_i,
   input wire logic tcc_valid_i,
   input wire logic [6:0] tcc_num_i,
   input wire logic [teu_pkg::TEU_CWP_W-1:0] spill_fill_cwp_i,
   input wire logic ret_i,
   input wire logic ret_replay_i,
   output logic trap_o,
   output logic [teu_pkg::TEU_ADDR_W-1:0] vector_o,
   output logic [teu_pkg::TEU_TT_W-1:0] trap_type_o,
   output logic [teu_pkg::TEU_CWP_W-1:0] cwp_o,
   output logic cwp_load_o,
   output logic ret_o,
   output logic [teu_pkg::TEU_ADDR_W-1:0] ret_pc_o,
   output logic [teu_pkg::TEU_ADDR_W-1:0] ret_npc_o,
   output logic [teu_pkg::TEU_TL_W-1:0] trap_level_o,
   output logic [1:0] global_level_o,
   output logic [11:0] processor_state_o,
   output logic irq_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);
   // ****************************************
   // state
   // ****************************************
   logic [31:0] trap_table_base_reg;
   logic [TEU_TL_W-1:0] tl_reg;
   logic [1:0] global_level_reg;
   logic [11:0] processor_state_reg;
   logic [TEU_EV_W-1:0] status_reg;
   logic [TEU_EV_W-1:0] mask_reg;
   logic [TEU_TT_W-1:0] last_tt_reg;
   logic [TEU_TL_W-1:0] sel_tl_reg;
   logic take;
   teu_src_t src;
   logic [TEU_TT_W-1:0] tt;
   logic [TEU_TL_W-1:0] tl_next;
   logic trap_now;
   logic ovf_now;
   logic ret_now;
   logic spill_fill;
   logic long_slot;
   logic [31:0] disp;
   teu_frame_t frame;
   teu_frame_t rd_frame;
   teu_frame_t sel_frame;
   logic [TEU_EV_W-1:0] events;

   // ****************************************
   // arbitration
   // ****************************************
   teu_prio u_prio (
      .exc_valid_i(exc_valid_i),
      .exc_tt_i(exc_tt_i),
      .async_valid_i(async_valid_i),
      .intr_valid_i(intr_valid_i && processor_state_reg[TEU_PS_IE]),
      .tcc_valid_i(tcc_valid_i),
      .tcc_num_i(tcc_num_i),
      .take_o(take),
      .src_o(src),
      .tt_o(tt)
   );

   // requests are only judged at an instruction boundary
   assign trap_now = issue_i && take && (tl_reg < TEU_TL_W'(MAX_TL));
   assign ovf_now = issue_i && take && (tl_reg >= TEU_TL_W'(MAX_TL));
   assign ret_now = issue_i && !take && ret_i && (tl_reg != '0);
   assign tl_next = tl_reg + TEU_TL_W'(1);
   assign spill_fill = (tt >= TEU_SPILL_LO) && (tt <= TEU_FILL_HI) && (src == TEU_SRC_EXC);
   assign long_slot = spill_fill || (tt >= TEU_FILL_LO && tt <= TEU_FILL_HI);

   // ****************************************
   // vector
   // ****************************************
   always_comb
   begin
      disp = {23'h0, tt} << TEU_SLOT_SHIFT;
      if (long_slot)
         disp = {23'h0, tt[TEU_TT_W-1:2], 2'b00} << TEU_SLOT_SHIFT;
      if (tl_reg != '0)
         disp = disp | (32'h1 << TEU_LEVEL_SHIFT);
   end

   // ****************************************
   // trap stack
   // ****************************************
   always_comb
   begin
      frame.pc = pc_i;
      frame.next_program_counter = next_pc_i;
      frame.st.condition_codes = condition_codes_i;
      frame.st.address_space_id = address_space_id_i;
      frame.st.processor_state = processor_state_reg;
      frame.st.current_window_pointer = current_window_pointer_i;
   end

   teu_stack #(
      .LEVELS(MAX_TL)
   ) u_stack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(trap_now),
      .wr_tl_i(tl_next),
      .wr_frame_i(frame),
      .rd_tl_i(tl_reg),
      .rd_frame_o(rd_frame)
   );

   teu_stack #(
      .LEVELS(MAX_TL)
   ) u_view (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(trap_now),
      .wr_tl_i(tl_next),
      .wr_frame_i(frame),
      .rd_tl_i(sel_tl_reg),
      .rd_frame_o(sel_frame)
   );

   // ****************************************
   // outputs to pipeline
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trap_o <= 1'b0;
         vector_o <= '0;
         trap_type_o <= '0;
         cwp_o <= '0;
         cwp_load_o <= 1'b0;
      end
      else
      begin
         trap_o <= trap_now;
         cwp_load_o <= trap_now && spill_fill;
         if (trap_now)
         begin
            vector_o <= {trap_table_base_reg[31:15], 15'h0} | disp;
            trap_type_o <= tt;
            cwp_o <= spill_fill ? spill_fill_cwp_i : current_window_pointer_i;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ret_o <= 1'b0;
         ret_pc_o <= '0;
         ret_npc_o <= '0;
      end
      else
      begin
         ret_o <= ret_now;
         if (ret_now)
         begin
            // replay form resumes at the saved pc, skip form at the saved next pc
            ret_pc_o <= ret_replay_i ? rd_frame.pc : rd_frame.next_program_counter;
            ret_npc_o <= ret_replay_i ? rd_frame.next_program_counter : rd_frame.next_program_counter + 32'h4;
         end
      end
   end

   // ****************************************
   // level and processor state
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tl_reg <= '0;
      else if (trap_now)
         tl_reg <= tl_next;
      else if (ret_now)
         tl_reg <= tl_reg - TEU_TL_W'(1);
   end

   logic ahb_wr;
   logic [7:0] ahb_addr;
   logic [31:0] ahb_rd;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         global_level_reg <= '0;
      else if (trap_now && global_level_reg != 2'(TEU_MAX_GL))
         global_level_reg <= global_level_reg + 2'd1;
      else if (ret_now && global_level_reg != '0)
         global_level_reg <= global_level_reg - 2'd1;
      else if (ahb_wr && ahb_addr == TEU_OFF_LEVEL)
         global_level_reg <= hwdata_i[9:8];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         processor_state_reg <= TEU_PROCESSOR_STATE_RST;
      else if (trap_now)
      begin
         // handlers run privileged, interrupts off, full addresses
         processor_state_reg[TEU_PS_PRIV] <= 1'b1;
         processor_state_reg[TEU_PS_IE] <= 1'b0;
         processor_state_reg[TEU_PS_AM] <= 1'b0;
      end
      else if (ret_now)
         processor_state_reg <= rd_frame.st.processor_state;
      else if (ahb_wr && ahb_addr == TEU_OFF_PROCESSOR_STATE)
         processor_state_reg <= hwdata_i[11:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         last_tt_reg <= '0;
      else if (trap_now)
         last_tt_reg <= tt;
   end

   assign trap_level_o = tl_reg;
   assign global_level_o = global_level_reg;
   assign processor_state_o = processor_state_reg;

   // ****************************************
   // interrupt status
   // ****************************************
   assign events = {ovf_now, ret_now, trap_now};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_reg <= '0;
      else if (ahb_wr && ahb_addr == TEU_OFF_STATUS)
         status_reg <= (status_reg & ~hwdata_i[TEU_EV_W-1:0]) | events;
      else
         status_reg <= status_reg | events;
   end

   assign irq_o = |(status_reg & mask_reg);

   // ****************************************
   // AHB-Lite slave: zero wait state, always OKAY
   // ****************************************
   logic dp_wr_reg;
   logic dp_rd_reg;
   logic [7:0] dp_addr_reg;
   logic ap_valid;

   assign ap_valid = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dp_wr_reg <= 1'b0;
         dp_rd_reg <= 1'b0;
         dp_addr_reg <= '0;
      end
      else if (hready_i)
      begin
         dp_wr_reg <= ap_valid && hwrite_i;
         dp_rd_reg <= ap_valid && !hwrite_i;
         dp_addr_reg <= haddr_i[7:0];
      end
   end

   assign ahb_wr = dp_wr_reg;
   assign ahb_addr = dp_addr_reg;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trap_table_base_reg <= TEU_TBASE_RST;
         mask_reg <= '0;
         sel_tl_reg <= '0;
      end
      else if (ahb_wr)
      begin
         if (ahb_addr == TEU_OFF_TBASE)
            trap_table_base_reg <= {hwdata_i[31:15], 15'h0};
         if (ahb_addr == TEU_OFF_MASK)
            mask_reg <= hwdata_i[TEU_EV_W-1:0];
         if (ahb_addr == TEU_OFF_SELTL)
            sel_tl_reg <= hwdata_i[TEU_TL_W-1:0];
      end
   end

   // read data is combinational in the data phase; unmapped reads give zero
   always_comb
   begin
      ahb_rd = '0;
      unique case (dp_addr_reg)
         TEU_OFF_TBASE: ahb_rd = trap_table_base_reg;
         TEU_OFF_STATUS: ahb_rd = {29'h0, status_reg};
         TEU_OFF_MASK: ahb_rd = {29'h0, mask_reg};
         TEU_OFF_LEVEL: ahb_rd = {22'h0, global_level_reg, 5'h0, tl_reg};
         TEU_OFF_PROCESSOR_STATE: ahb_rd = {20'h0, processor_state_reg};
         TEU_OFF_LAST: ahb_rd = {23'h0, last_tt_reg};
         TEU_OFF_SPC: ahb_rd = sel_frame.pc;
         TEU_OFF_SNPC: ahb_rd = sel_frame.next_program_counter;
         TEU_OFF_SSTATE: ahb_rd = {1'b0, sel_frame.st};
         TEU_OFF_SELTL: ahb_rd = {29'h0, sel_tl_reg};
         default: ahb_rd = '0;
      endcase
   end

   assign hrdata_o = dp_rd_reg ? ahb_rd : 32'h0;

   // ****************************************
   // checks
   // ****************************************
   AST_LEVEL_UP: assert property (@(posedge clk_i) disable iff (rst_i) trap_now |=> tl_reg == $past(tl_reg) + TEU_TL_W'(1))
      else $error("trap level did not rise on entry");
   AST_SAVE_PC: assert property (@(posedge clk_i) disable iff (rst_i) trap_now ##2 (ret_i && issue_i && !take && ret_replay_i) |=> ret_pc_o == $past(pc_i, 3))
      else $error("saved pc not returned");
   AST_VEC: assert property (@(posedge clk_i) disable iff (rst_i) trap_now |=> vector_o[31:15] == trap_table_base_reg[31:15] && trap_o)
      else $error("vector base wrong");
   AST_SW_REGION: assert property (@(posedge clk_i) disable iff (rst_i) (trap_now && src == TEU_SRC_TCC) |=> trap_type_o[8])
      else $error("software trap outside upper region");
   AST_PRIV: assert property (@(posedge clk_i) disable iff (rst_i) trap_now |=> processor_state_reg[TEU_PS_PRIV] && !processor_state_reg[TEU_PS_IE])
      else $error("state bits not set on entry");
   AST_CWP: assert property (@(posedge clk_i) disable iff (rst_i) (trap_now && !spill_fill) |=> !cwp_load_o ##0 cwp_o == $past(current_window_pointer_i))
      else $error("window pointer changed");
   AST_PRIO: assert property (@(posedge clk_i) disable iff (rst_i) (issue_i && async_valid_i && exc_valid_i) |=> trap_type_o == TEU_ASYNC_TT || !trap_o)
      else $error("priority order broken");
   AST_NOISSUE: assert property (@(posedge clk_i) disable iff (rst_i) !issue_i |=> !trap_o && !ret_o)
      else $error("trap taken off an instruction boundary");
   AST_STATE: assert property (@(posedge clk_i) disable iff (rst_i) (trap_now ##2 (issue_i && !take && ret_i)) |=> processor_state_reg == $past(frame.st.processor_state, 3))
      else $error("saved state not restored");
   AST_SLOT: assert property (@(posedge clk_i) disable iff (rst_i) trap_now |=> vector_o[4:0] == 5'h00)
      else $error("vector not slot aligned");
   AST_DEPTH: assert property (@(posedge clk_i) disable iff (rst_i) tl_reg <= TEU_TL_W'(MAX_TL))
      else $error("trap level beyond stack depth");
   AST_RET: assert property (@(posedge clk_i) disable iff (rst_i) ret_now |=> ret_o && tl_reg == $past(tl_reg) - TEU_TL_W'(1))
      else $error("return did not pop");
   COV_TRAP: cover property (@(posedge clk_i) disable iff (rst_i) trap_now);
   COV_NEST: cover property (@(posedge clk_i) disable iff (rst_i) trap_now ##[1:20] trap_now);
   COV_RET: cover property (@(posedge clk_i) disable iff (rst_i) trap_now ##[1:20] ret_now);
   COV_SPILL: cover property (@(posedge clk_i) disable iff (rst_i) trap_now && spill_fill);
endmodule // teu_top

// File: verif/teu_pipe_model.sv
// pipeline partner model: instruction boundaries carrying trap and return requests
`timescale 1ns/10ps
module teu_pipe_model
   import teu_pkg::*;
(
   input wire logic clk_i,
   output logic issue_o,
   output logic [31:0] pc_o,
   output logic [31:0] next_pc_o,
   output logic [7:0] codes_o,
   output logic [7:0] space_o,
   output logic [2:0] window_o,
   output logic [2:0] sf_window_o,
   output logic [3:0] src_o,
   output logic [8:0] tt_o,
   output logic [6:0] num_o,
   output logic ret_o,
   output logic replay_o
);
   initial
   begin
      {issue_o, src_o, tt_o, num_o, ret_o, replay_o} = '0;
      {pc_o, next_pc_o, codes_o, space_o, window_o, sf_window_o} = '0;
   end

   // one boundary per call; src is {trap insn, interrupt, exception, async};
   // off the boundary the requests clear and the pc and state fields turn to their inverse, so a late sample shows
   task automatic boundary(input logic [3:0] src, input logic [8:0] tt, input logic [6:0] num,
      input logic [1:0] rt, input logic [31:0] pcv);
      @(posedge clk_i);
      issue_o <= 1'b1;
      {src_o, tt_o, num_o, ret_o, replay_o} <= {src, tt, num, rt};
      {pc_o, next_pc_o} <= {pcv, pcv + 32'h4};
      {codes_o, space_o, window_o, sf_window_o} <= {pcv[15:8], pcv[23:16], pcv[26:24], ~pcv[26:24]};
      @(posedge clk_i);
      {issue_o, src_o, tt_o, num_o, ret_o, replay_o} <= '0;
      {pc_o, next_pc_o, codes_o, space_o, window_o, sf_window_o} <=
         ~{pc_o, next_pc_o, codes_o, space_o, window_o, sf_window_o};
   endtask
endmodule // teu_pipe_model

// File: verif/teu_top_tb.sv
// self-checking bench for the trap entry unit
`timescale 1ns/10ps
module teu_top_tb;
   import teu_pkg::*;
   logic clk_i, rst_i, issue_i, exc_valid_i, async_valid_i, intr_valid_i, tcc_valid_i, ret_i, ret_replay_i;
   logic [31:0] pc_i, next_pc_i, vector_o, ret_pc_o, ret_npc_o, haddr_i, hwdata_i, hrdata_o, rd, base;
   logic [7:0] condition_codes_i, address_space_id_i;
   logic [2:0] current_window_pointer_i, spill_fill_cwp_i, cwp_o, trap_level_o, hsize_i;
   logic [8:0] exc_tt_i, trap_type_o;
   logic [6:0] tcc_num_i;
   logic [1:0] global_level_o, htrans_i;
   logic [11:0] processor_state_o, ps;
   logic [3:0] src;
   logic trap_o, cwp_load_o, ret_o, irq_o, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
   logic [31:0] saved_pc [1:6];
   logic [11:0] saved_ps [1:6];
   int errors, samples_checked, tl, glev;

   assign {tcc_valid_i, intr_valid_i, exc_valid_i, async_valid_i} = src;
   assign hready_i = hreadyout_o;

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   teu_top #(.MAX_TL(6)) u_teu_top (.clk_i, .rst_i, .issue_i, .pc_i, .next_pc_i, .condition_codes_i,
      .address_space_id_i, .current_window_pointer_i, .exc_valid_i, .exc_tt_i, .async_valid_i, .intr_valid_i,
      .tcc_valid_i, .tcc_num_i, .spill_fill_cwp_i, .ret_i, .ret_replay_i, .trap_o, .vector_o, .trap_type_o,
      .cwp_o, .cwp_load_o, .ret_o, .ret_pc_o, .ret_npc_o, .trap_level_o, .global_level_o, .processor_state_o,
      .irq_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
      .hresp_o);

   teu_pipe_model u_teu_pipe_model (.clk_i, .issue_o(issue_i), .pc_o(pc_i), .next_pc_o(next_pc_i),
      .codes_o(condition_codes_i), .space_o(address_space_id_i), .window_o(current_window_pointer_i),
      .sf_window_o(spill_fill_cwp_i), .src_o(src), .tt_o(exc_tt_i), .num_o(tcc_num_i), .ret_o(ret_i),
      .replay_o(ret_replay_i));

   // ****************************************
   // tasks
   // ****************************************
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (hready_i !== 1'b1 && n < 40);
      if (hready_i !== 1'b1)
      begin
         errors++;
         complete_run();
      end
   endtask

   // an idle edge ahead of each address phase keeps back-to-back calls from driving twice in one step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'b10, 24'h0, a, wr};
      wait_ready();
      {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'b00, wd};
      wait_ready();
      rd = hrdata_o;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic step(input logic [3:0] s, input logic [8:0] tt, input logic [6:0] num,
      input logic [31:0] pcv, input logic [8:0] tte);
      logic sf;
      logic [8:0] slot;
      logic [11:0] ps0;
      sf = tte >= TEU_SPILL_LO && tte <= TEU_FILL_HI;
      slot = sf ? tte & 9'h1FC : tte;
      ps0 = ps;
      u_teu_pipe_model.boundary(s, tt, num, 2'b00, pcv);
      #1;
      chk("trap", 1, trap_o);
      chk("type", tte, trap_type_o);
      chk("vector", {base[31:15], 15'h0} | {17'h0, tl != 0, slot, 5'h0}, vector_o);
      chk("window_load", sf, cwp_load_o);
      if (sf)
         chk("window", 3'(~pcv[26:24]), cwp_o);
      else
         chk("window", pcv[26:24], cwp_o);
      tl++;
      glev = glev < 3 ? glev + 1 : 3;
      ps = ps & 12'hFF5 | 12'h004;
      saved_pc[tl] = pcv;
      saved_ps[tl] = ps0;
      chk("level", tl, trap_level_o);
      chk("global", glev, global_level_o);
      chk("state", ps, processor_state_o);
      bus(1'b1, TEU_OFF_SELTL, tl);
      rchk("saved_pc", TEU_OFF_SPC, pcv);
      rchk("saved_next", TEU_OFF_SNPC, pcv + 4);
      rchk("saved_state", TEU_OFF_SSTATE, {1'b0, pcv[15:8], pcv[23:16], ps0, pcv[26:24]});
   endtask

   task automatic back(input logic rp);
      u_teu_pipe_model.boundary(4'h0, 9'h0, 7'h0, {1'b1, rp}, 32'h0);
      #1;
      chk("ret", 1, ret_o);
      chk("ret_pc", rp ? saved_pc[tl] : saved_pc[tl] + 4, ret_pc_o);
      chk("ret_next", rp ? saved_pc[tl] + 4 : saved_pc[tl] + 8, ret_npc_o);
      chk("state", saved_ps[tl], processor_state_o);
      tl--;
      glev--;
      chk("level", tl, trap_level_o);
      chk("global", glev, global_level_o);
   endtask

   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      {errors, samples_checked, tl, glev} = '0;
      {hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = '0;
      rst_i = 1'b1;
      hsize_i = 3'b010;
      ps = 12'h004;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("state", ps, processor_state_o);
      chk("vector", 0, vector_o);
      chk("outputs", 0, {trap_o, ret_o, irq_o, hresp_o, trap_level_o, global_level_o});
      rchk("base", TEU_OFF_TBASE, 32'h0);
      bus(1'b1, TEU_OFF_TBASE, 32'hFFFF_FFFF);
      rchk("base", TEU_OFF_TBASE, 32'hFFFF_8000);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rchk("unmapped", 8'h40, 32'h0);
      base = 32'h1234_8000;
      bus(1'b1, TEU_OFF_TBASE, base);
      ps = 12'h00E;
      bus(1'b1, TEU_OFF_PROCESSOR_STATE, ps);
      $display("test registers done");
      step(4'hF, 9'h005, 7'h11, 32'h0123_4560, TEU_ASYNC_TT);
      step(4'hE, 9'h005, 7'h11, 32'h0345_6780, 9'h005);
      u_teu_pipe_model.boundary(4'h4, 9'h0, 7'h0, 2'b00, 32'h0);
      #1;
      chk("masked_intr", 0, trap_o);
      ps = 12'h006;
      bus(1'b1, TEU_OFF_PROCESSOR_STATE, ps);
      step(4'hC, 9'h0, 7'h22, 32'h0567_89A0, TEU_INTR_TT);
      step(4'h8, 9'h0, 7'h7F, 32'h0789_ABC0, 9'h17F);
      step(4'h2, 9'h0C7, 7'h0, 32'h02AB_CDE0, 9'h0C7);
      ps = 12'h00C;
      bus(1'b1, TEU_OFF_PROCESSOR_STATE, ps);
      step(4'h2, 9'h085, 7'h0, 32'h04CD_EF00, 9'h085);
      u_teu_pipe_model.boundary(4'h2, 9'h005, 7'h0, 2'b00, 32'h0);
      #1;
      chk("overflow", 0, trap_o);
      chk("level", 6, trap_level_o);
      bus(1'b1, TEU_OFF_SELTL, 32'h1);
      rchk("saved_pc", TEU_OFF_SPC, saved_pc[1]);
      $display("test trap entry done");
      back(1'b1);
      back(1'b0);
      // return two cycles after entry, with no register traffic between
      u_teu_pipe_model.boundary(4'h2, 9'h005, 7'h0, 2'b00, 32'h0ACE_1230);
      #1;
      chk("trap", 1, trap_o);
      tl++;
      glev++;
      saved_pc[tl] = 32'h0ACE_1230;
      saved_ps[tl] = ps;
      back(1'b1);
      rchk("last", TEU_OFF_LAST, 32'h0000_0005);
      bus(1'b1, TEU_OFF_LEVEL, 32'h0000_0300);
      rchk("level_reg", TEU_OFF_LEVEL, 32'h0000_0304);
      $display("test return done");
      rchk("status", TEU_OFF_STATUS, 32'h7);
      chk("irq", 0, irq_o);
      bus(1'b1, TEU_OFF_MASK, 32'h4);
      @(posedge clk_i);
      #1;
      chk("irq", 1, irq_o);
      bus(1'b1, TEU_OFF_STATUS, 32'h4);
      @(posedge clk_i);
      #1;
      chk("irq", 0, irq_o);
      rchk("status", TEU_OFF_STATUS, 32'h3);
      $display("test interrupt done");
      complete_run();
   end
endmodule // teu_top_tb
